// ### rtl/tctr_top.sv
// three-channel down-counting timer with its register file on an AXI4-Lite slave
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
module tctr_top
    import tctr_pkg::*;
(
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic                   ce,
    input  wire tctr_pkg::tctr_axi_req_t axi_req,
    output tctr_pkg::tctr_axi_rsp_t     axi_rsp,
    input  wire logic                   standby_mode,
    input  wire logic                   first_multiplier_change,
    input  wire logic                   module_stop_bit,
    input  wire logic                   rtc_output_clock,
    input  wire logic                   ext_timer_clock_pin_in,
    output logic                        ext_timer_clock_pin_out,
    output logic                        ext_timer_clock_pin_oe,
    output logic [2:0]                  underflow_interrupt,
    output logic                        capture_interrupt,
    output logic                        irq
);
    import tctr_pkg::*;

    typedef struct packed {
        logic                   pin_ctl;
        logic [2:0]             run;
        tctr_ctl_t [2:0]        ctl;
        logic [2:0][31:0]       reload;
        logic [2:0][31:0]       count;
        logic [31:0]            capture;
        logic [3:0]             irq_status;
        logic [3:0]             irq_mask;
        logic [7:0]             presc;
        logic [2:0]             pin_sync;
        logic [2:0]             rtc_sync;
        logic                   aw_got;
        logic [31:0]            awaddr;
        logic                   w_got;
        logic [31:0]            wdata;
        logic [3:0]             wstrb;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   rvalid;
        logic [31:0]            rdata;
        logic [1:0]             rresp;
        logic [7:0]             rd_idx;
    } tctr_state_t;

    localparam tctr_state_t STATE_RST = '{
        pin_ctl:    PIN_CTL_RST[0],
        run:        RUN_RST[2:0],
        ctl:        {3{tctr_ctl_t'(CTL_RST)}},
        reload:     {3{RELOAD_RST}},
        count:      {3{COUNT_RST}},
        irq_status: IRQ_RST,
        irq_mask:   IRQ_RST,
        default:    '0
    };

    tctr_state_t r;
    tctr_state_t next_r;

    logic        ext_rise;
    logic        ext_fall;
    logic        rtc_rise;
    logic        power_event;
    logic        wr_fire;
    logic [7:0]  wr_idx;
    logic [7:0]  ar_idx;
    logic [2:0]  tick;
    logic [2:0]  sync_src;
    logic [2:0]  unf_set;
    logic        cap_evt;
    logic [31:0] wr_val;
    logic [32:0] wr_look;
    logic [32:0] rd_look;
    tctr_ctl_t   new_ctl;

    // stage 0 of each synchroniser feeds stage 1 only
    assign ext_rise    = r.pin_sync[1] & ~r.pin_sync[2];
    assign ext_fall    = ~r.pin_sync[1] & r.pin_sync[2];
    assign rtc_rise    = r.rtc_sync[1] & ~r.rtc_sync[2];
    assign power_event = standby_mode | first_multiplier_change | module_stop_bit;
    assign wr_fire     = r.aw_got & r.w_got & ~r.bvalid;
    assign wr_idx      = r.awaddr[9:2];
    assign ar_idx      = axi_req.araddr[9:2];

    function automatic logic ext_hit(input logic [1:0] sel, input logic rise,
                                     input logic fall);
        if (sel[1])
            return rise | fall;
        else if (sel == EDGE_FALL)
            return fall;
        else
            return rise;
    endfunction : ext_hit

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] st);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (st[b])
                res[8*b +: 8] = wd[8*b +: 8];
        end
        return res;
    endfunction : merge

    // bit 32 is the hit flag; the word is taken from one state snapshot
    function automatic logic [32:0] rd_mux(input tctr_state_t s, input logic [7:0] idx);
        logic [32:0] res;
        res = {1'b0, 32'h0000_0000};
        if (idx == OFS_PIN_CONTROL[7:0])
            res = {1'b1, 31'h0000_0000, s.pin_ctl};
        else if (idx == OFS_RUN_SELECT[7:0])
            res = {1'b1, 29'h0000_0000, s.run};
        else if (idx == OFS_CAPTURE_2[7:0])
            res = {1'b1, s.capture};
        else if (idx == OFS_IRQ_STATUS[7:0])
            res = {1'b1, 28'h000_0000, s.irq_status};
        else if (idx == OFS_IRQ_MASK[7:0])
            res = {1'b1, 28'h000_0000, s.irq_mask};
        for (int c = 0; c < 3; c++)
        begin
            if (idx == OFS_RELOAD[c][7:0])
                res = {1'b1, s.reload[c]};
            if (idx == OFS_COUNT[c][7:0])
                res = {1'b1, s.count[c]};
            if (idx == OFS_CONTROL[c][7:0])
                res = {1'b1, 16'h0000, s.ctl[c]};
        end
        return res;
    endfunction : rd_mux

    assign wr_look = rd_mux(r, wr_idx);
    assign rd_look = rd_mux(r, ar_idx);
    assign wr_val  = merge(wr_look[31:0], r.wdata, r.wstrb);

    generate
        for (genvar g = 0; g < 3; g++)
        begin : g_tick
            logic sel_hit;
            assign sync_src[g] = (r.ctl[g].clk_sel != CLK_RTC);
            assign tick[g]     = sel_hit;
            always_comb
            begin
                unique case (r.ctl[g].clk_sel)
                    CLK_PDIV4:   sel_hit = &r.presc[1:0];
                    CLK_PDIV16:  sel_hit = &r.presc[3:0];
                    CLK_PDIV64:  sel_hit = &r.presc[5:0];
                    CLK_PDIV256: sel_hit = &r.presc[7:0];
                    CLK_RTC:     sel_hit = rtc_rise;
                    CLK_EXT:     sel_hit = ~r.pin_ctl & ext_hit(r.ctl[g].edge_sel,
                                                                ext_rise, ext_fall);
                    default:     sel_hit = 1'b0;
                endcase
            end
        end
    endgenerate

    assign cap_evt = r.ctl[2].icpe[1] & ~r.pin_ctl
                   & ext_hit(r.ctl[2].edge_sel, ext_rise, ext_fall);

    always_comb
    begin
        next_r  = r;
        unf_set = 3'b000;
        new_ctl = tctr_ctl_t'(CTL_RST);

        next_r.pin_sync = {r.pin_sync[1:0], ext_timer_clock_pin_in};
        next_r.rtc_sync = {r.rtc_sync[1:0], rtc_output_clock};
        next_r.presc    = r.presc + 8'h01;

        // bus handshakes
        if (axi_req.awvalid && axi_rsp.awready)
        begin
            next_r.aw_got = 1'b1;
            next_r.awaddr = axi_req.awaddr;
        end
        if (axi_req.wvalid && axi_rsp.wready)
        begin
            next_r.w_got = 1'b1;
            next_r.wdata = axi_req.wdata;
            next_r.wstrb = axi_req.wstrb;
        end
        if (r.bvalid && axi_req.bready)
            next_r.bvalid = 1'b0;
        if (r.rvalid && axi_req.rready)
            next_r.rvalid = 1'b0;
        if (axi_req.arvalid && axi_rsp.arready)
        begin
            next_r.rvalid = 1'b1;
            next_r.rdata  = rd_look[31:0];
            next_r.rresp  = rd_look[32] ? RESP_OKAY : RESP_SLVERR;
            next_r.rd_idx = ar_idx;
        end

        // counting
        for (int c = 0; c < 3; c++)
        begin
            if (r.run[c] && tick[c] && !(power_event && sync_src[c]))
            begin
                if (r.count[c] == 32'h0000_0000)
                begin
                    next_r.count[c] = r.reload[c];
                    unf_set[c]      = 1'b1;
                end
                else
                    next_r.count[c] = r.count[c] - 32'h0000_0001;
            end
        end
        if (cap_evt)
            next_r.capture = r.count[2];

        // software write
        if (wr_fire)
        begin
            next_r.aw_got = 1'b0;
            next_r.w_got  = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp  = wr_look[32] ? RESP_OKAY : RESP_SLVERR;
            if (wr_idx == OFS_PIN_CONTROL[7:0])
                next_r.pin_ctl = wr_val[0];
            if (wr_idx == OFS_RUN_SELECT[7:0])
                next_r.run = wr_val[2:0];
            if (wr_idx == OFS_CAPTURE_2[7:0])
                next_r.capture = wr_val;
            if (wr_idx == OFS_IRQ_STATUS[7:0])
                next_r.irq_status = r.irq_status & ~wr_val[3:0];
            if (wr_idx == OFS_IRQ_MASK[7:0])
                next_r.irq_mask = wr_val[3:0];
            for (int c = 0; c < 3; c++)
            begin
                if (wr_idx == OFS_RELOAD[c][7:0])
                    next_r.reload[c] = wr_val;
                if (wr_idx == OFS_COUNT[c][7:0])
                    next_r.count[c] = wr_val;
                if (wr_idx == OFS_CONTROL[c][7:0] && !(power_event && sync_src[c]))
                begin
                    new_ctl      = tctr_ctl_t'(wr_val[15:0]);
                    new_ctl.rsvd = 6'h00;
                    new_ctl.unf  = r.ctl[c].unf & new_ctl.unf;
                    new_ctl.icpf = r.ctl[c].icpf & new_ctl.icpf;
                    if (c != 2)
                    begin
                        new_ctl.icpf = 1'b0;
                        new_ctl.icpe = ICPE_OFF;
                    end
                    else if (new_ctl.icpe == ICPE_RSVD)
                        new_ctl.icpe = r.ctl[c].icpe;
                    next_r.ctl[c] = new_ctl;
                end
            end
        end

        // power events stop channels that run from the pin or peripheral clock
        for (int c = 0; c < 3; c++)
        begin
            if (power_event && sync_src[c])
                next_r.run[c] = 1'b0;
        end

        // flags: a set in the same cycle as a clear wins
        for (int c = 0; c < 3; c++)
        begin
            next_r.ctl[c].unf = next_r.ctl[c].unf | unf_set[c];
        end
        next_r.ctl[2].icpf = next_r.ctl[2].icpf | cap_evt;
        next_r.irq_status  = next_r.irq_status | {cap_evt, unf_set};
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            r <= STATE_RST;
        else if (ce)
            r <= next_r;
    end

    always_comb
    begin
        axi_rsp.awready = ce & ~r.aw_got & ~r.bvalid;
        axi_rsp.wready  = ce & ~r.w_got & ~r.bvalid;
        axi_rsp.bvalid  = r.bvalid;
        axi_rsp.bresp   = r.bresp;
        axi_rsp.arready = ce & ~r.rvalid;
        axi_rsp.rvalid  = r.rvalid;
        axi_rsp.rdata   = r.rdata;
        axi_rsp.rresp   = r.rresp;
    end

    assign ext_timer_clock_pin_oe  = r.pin_ctl;
    assign ext_timer_clock_pin_out = r.pin_ctl & r.rtc_sync[1];

    generate
        for (genvar g = 0; g < 3; g++)
        begin : g_irq
            assign underflow_interrupt[g] = r.ctl[g].unf & r.ctl[g].underflow_irq_enable;
        end
    endgenerate

    assign capture_interrupt = r.ctl[2].icpf & (r.ctl[2].icpe == ICPE_IRQ);
    assign irq               = |(r.irq_status & r.irq_mask);

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    chk_reset_ones: assert property (
        $past(!aresetn) |-> (r.reload[0] == RELOAD_RST) && (r.count[2] == COUNT_RST))
        else $error("reload or count not all ones after reset");

    chk_pin_reset: assert property (
        $past(!aresetn) |-> !r.pin_ctl && !ext_timer_clock_pin_oe && (r.run == 3'b000))
        else $error("pin control or run select not cleared by reset");

    chk_pin_drive: assert property (
        $past(ce) && $past(ce, 2) && r.pin_ctl
        |-> ext_timer_clock_pin_oe && (ext_timer_clock_pin_out == $past(rtc_output_clock, 2)))
        else $error("pin does not follow rtc clock in output mode");

    chk_rsvd_read: assert property (
        r.rvalid && ((r.rd_idx == OFS_PIN_CONTROL[7:0]) || (r.rd_idx == OFS_RUN_SELECT[7:0]))
        |-> (r.rdata[31:3] == 29'h0000_0000))
        else $error("reserved bits read nonzero");

    chk_halt_hold: assert property (
        ce && !r.run[0] && !wr_fire |=> $stable(r.count[0]))
        else $error("halted counter changed");

    chk_standby_halt: assert property (
        ce && standby_mode && (r.ctl[0].clk_sel != CLK_RTC) |=> !r.run[0])
        else $error("run bit kept through power event");

    chk_ctl_retain: assert property (
        ce && module_stop_bit && (r.ctl[0].clk_sel != CLK_RTC) |=> $stable(r.ctl[0]))
        else $error("control changed during module stop");

    chk_unf_reload: assert property (
        ce && r.run[0] && tick[0] && (r.count[0] == 32'h0000_0000) && !wr_fire
        && !(power_event && sync_src[0])
        |=> (r.count[0] == $past(r.reload[0])) && r.ctl[0].unf)
        else $error("underflow did not reload and flag");

    chk_unf_set_wins: assert property (
        ce && unf_set[0] |=> r.ctl[0].unf && r.irq_status[0])
        else $error("underflow flag lost");

    chk_unf_irq: assert property (
        ce && unf_set[0] && r.ctl[0].underflow_irq_enable && !wr_fire |=> underflow_interrupt[0])
        else $error("underflow interrupt not raised");

    chk_rsvd_ctl: assert property (
        (r.ctl[0].rsvd == 6'h00) && !r.ctl[1].icpf && (r.ctl[0].icpe == ICPE_OFF))
        else $error("reserved control bits set");

    chk_capture_take: assert property (
        ce && cap_evt && !wr_fire |=> (r.capture == $past(r.count[2])) && r.ctl[2].icpf)
        else $error("capture did not store counter");

endmodule : tctr_top

// ### rtl/tctr_pkg.sv
// package: register map, field layouts, reset values and bus carriers of the timer
package tctr_pkg;

    // printed offsets are register indexes; byte address is four times the index
    localparam logic [31:0] OFS_PIN_CONTROL  = 32'hFFFFFE90;
    localparam logic [31:0] OFS_RUN_SELECT   = 32'hFFFFFE92;
    localparam logic [31:0] OFS_RELOAD_0     = 32'hFFFFFE94;
    localparam logic [31:0] OFS_COUNT_0      = 32'hFFFFFE98;
    localparam logic [31:0] OFS_CONTROL_0    = 32'hFFFFFE9C;
    localparam logic [31:0] OFS_RELOAD_1     = 32'hFFFFFEA0;
    localparam logic [31:0] OFS_COUNT_1      = 32'hFFFFFEA4;
    localparam logic [31:0] OFS_CONTROL_1    = 32'hFFFFFEA8;
    localparam logic [31:0] OFS_RELOAD_2     = 32'hFFFFFEAC;
    localparam logic [31:0] OFS_COUNT_2      = 32'hFFFFFEB0;
    localparam logic [31:0] OFS_CONTROL_2    = 32'h0FFFFEB4;
    localparam logic [31:0] OFS_CAPTURE_2    = 32'hFFFFFEB8;
    localparam logic [31:0] OFS_IRQ_STATUS   = 32'hFFFFFEC0;
    localparam logic [31:0] OFS_IRQ_MASK     = 32'hFFFFFEC1;

    localparam logic [2:0][31:0] OFS_RELOAD  = {OFS_RELOAD_2, OFS_RELOAD_1, OFS_RELOAD_0};
    localparam logic [2:0][31:0] OFS_COUNT   = {OFS_COUNT_2, OFS_COUNT_1, OFS_COUNT_0};
    localparam logic [2:0][31:0] OFS_CONTROL = {OFS_CONTROL_2, OFS_CONTROL_1, OFS_CONTROL_0};

    localparam logic [7:0]  PIN_CTL_RST = 8'h00;
    localparam logic [7:0]  RUN_RST     = 8'h00;
    localparam logic [15:0] CTL_RST     = 16'h0000;
    localparam logic [31:0] RELOAD_RST  = 32'hFFFFFFFF;
    localparam logic [31:0] COUNT_RST   = 32'hFFFFFFFF;
    localparam logic [3:0]  IRQ_RST     = 4'h0;

    // clock select codes
    localparam logic [2:0] CLK_PDIV4   = 3'h0;
    localparam logic [2:0] CLK_PDIV16  = 3'h1;
    localparam logic [2:0] CLK_PDIV64  = 3'h2;
    localparam logic [2:0] CLK_PDIV256 = 3'h3;
    localparam logic [2:0] CLK_RTC     = 3'h4;
    localparam logic [2:0] CLK_EXT     = 3'h5;

    // edge select and capture control codes
    localparam logic [1:0] EDGE_RISE   = 2'h0;
    localparam logic [1:0] EDGE_FALL   = 2'h1;
    localparam logic [1:0] ICPE_OFF    = 2'h0;
    localparam logic [1:0] ICPE_RSVD   = 2'h1;
    localparam logic [1:0] ICPE_NOIRQ  = 2'h2;
    localparam logic [1:0] ICPE_IRQ    = 2'h3;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int         IRQ_CAPTURE = 3;

    typedef struct packed {
        logic [5:0] rsvd;
        logic       icpf;
        logic       unf;
        logic [1:0] icpe;
        logic       underflow_irq_enable;
        logic [1:0] edge_sel;
        logic [2:0] clk_sel;
    } tctr_ctl_t;

    typedef struct packed {
        logic        awvalid;
        logic [31:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [31:0] araddr;
        logic        rready;
    } tctr_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } tctr_axi_rsp_t;

endpackage : tctr_pkg

// ### verif/tctr_top_test.sv
// self-checking bench for the three-channel timer register block
`timescale 1ns/1ps
module tctr_top_test;
    import tctr_pkg::*;

    logic          aclk;
    logic          aresetn;
    tctr_axi_req_t req;
    tctr_axi_rsp_t rsp;
    logic          standby_mode;
    logic          mult_change;
    logic          stop_bit;
    logic          rtc_clk;
    logic [2:0]    rtc_div;
    logic          pin_in;
    logic          pin_out;
    logic          pin_oe;
    logic [2:0]    unf_irq;
    logic          cap_irq;
    logic          irq;
    logic [1:0]    resp;
    logic [31:0]   rd;
    int            err_count;
    int            checks_done;

    tctr_top dut_u (
        .aclk                    (aclk),
        .aresetn                 (aresetn),
        .ce                      (1'b1),
        .axi_req                 (req),
        .axi_rsp                 (rsp),
        .standby_mode            (standby_mode),
        .first_multiplier_change (mult_change),
        .module_stop_bit         (stop_bit),
        .rtc_output_clock        (rtc_clk),
        .ext_timer_clock_pin_in  (pin_in),
        .ext_timer_clock_pin_out (pin_out),
        .ext_timer_clock_pin_oe  (pin_oe),
        .underflow_interrupt     (unf_irq),
        .capture_interrupt       (cap_irq),
        .irq                     (irq)
    );

    initial
    begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    // slow stand-in for the rtc clock, derived from aclk at one sixteenth of its rate
    always @(posedge aclk)
    begin
        rtc_div <= rtc_div + 3'h1;
        if (rtc_div == 3'h7)
            rtc_clk <= ~rtc_clk;
    end

    function automatic logic [31:0] baddr(input logic [31:0] ofs);
        return {ofs[29:0], 2'b00};
    endfunction : baddr

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict

    task automatic timed_out();
        err_count++;
        give_verdict();
    endtask : timed_out

    task automatic axi_write(input logic [31:0] ofs, input logic [31:0] data,
                             output logic [1:0] br);
        logic ta;
        logic tw;
        logic got;
        int   n;
        got = 1'b0;
        @(posedge aclk);
        req.awaddr  <= baddr(ofs);
        req.wdata   <= data;
        req.wstrb   <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid  <= 1'b1;
        req.bready  <= 1'b1;
        for (n = 0; n < 200 && !got; n++)
        begin
            @(negedge aclk);
            ta = rsp.awready === 1'b1;
            tw = rsp.wready === 1'b1;
            got = rsp.bvalid === 1'b1;
            br = rsp.bresp;
            @(posedge aclk);
            if (ta)
                req.awvalid <= 1'b0;
            if (tw)
                req.wvalid <= 1'b0;
        end
        req.bready <= 1'b0;
        if (!got)
            timed_out();
    endtask : axi_write

    task automatic axi_read(input logic [31:0] ofs, output logic [31:0] data,
                            output logic [1:0] rr);
        logic ta;
        logic got;
        int   n;
        got = 1'b0;
        @(posedge aclk);
        req.araddr  <= baddr(ofs);
        req.arvalid <= 1'b1;
        req.rready  <= 1'b1;
        for (n = 0; n < 200 && !got; n++)
        begin
            @(negedge aclk);
            ta = rsp.arready === 1'b1;
            got = rsp.rvalid === 1'b1;
            data = rsp.rdata;
            rr = rsp.rresp;
            @(posedge aclk);
            if (ta)
                req.arvalid <= 1'b0;
        end
        req.rready <= 1'b0;
        if (!got)
            timed_out();
    endtask : axi_read

    task automatic wr(input logic [31:0] ofs, input logic [31:0] data);
        logic [1:0] br;
        axi_write(ofs, data, br);
        check(br, RESP_OKAY);
    endtask : wr

    task automatic expect_reg(input logic [31:0] ofs, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  rr;
        axi_read(ofs, d, rr);
        check(rr, RESP_OKAY);
        check(d, exp);
    endtask : expect_reg

    task automatic wait_event(input int which);
        int n;
        for (n = 0; n < 4000 && ((which == 1) ? cap_irq : unf_irq[0]) !== 1'b1; n++)
            @(negedge aclk);
        if (n == 4000)
            timed_out();
    endtask : wait_event

    task automatic test_reset();
        expect_reg(OFS_PIN_CONTROL, 32'h00000000);
        expect_reg(OFS_RUN_SELECT, 32'h00000000);
        for (int c = 0; c < 3; c++)
        begin
            expect_reg(OFS_RELOAD[c], 32'hFFFFFFFF);
            expect_reg(OFS_COUNT[c], 32'hFFFFFFFF);
            expect_reg(OFS_CONTROL[c], 32'h00000000);
        end
        $display("test reset_values done");
    endtask : test_reset

    task automatic test_reserved();
        wr(OFS_PIN_CONTROL, 32'h000000FF);
        expect_reg(OFS_PIN_CONTROL, 32'h00000001);
        @(negedge aclk);
        check(pin_oe, 1'b1);
        for (int n = 0; n < 40 && pin_out !== 1'b1; n++)
            @(negedge aclk);
        check(pin_out, 1'b1);
        wr(OFS_PIN_CONTROL, 32'h00000000);
        @(negedge aclk);
        check(pin_oe, 1'b0);
        check(pin_out, 1'b0);
        wr(OFS_RUN_SELECT, 32'h000000F8);
        expect_reg(OFS_RUN_SELECT, 32'h00000000);
        wr(OFS_CONTROL_0, 32'h0000FFFF);
        expect_reg(OFS_CONTROL_0, 32'h0000003F);
        wr(OFS_CONTROL_2, 32'h0000FFFF);
        expect_reg(OFS_CONTROL_2, 32'h000000FF);
        wr(OFS_CONTROL_0, 32'h00000000);
        wr(OFS_CONTROL_2, 32'h00000000);
        axi_write(32'h00000000, 32'hFFFFFFFF, resp);
        check(resp, RESP_SLVERR);
        axi_read(32'h00000000, rd, resp);
        check(resp, RESP_SLVERR);
        check(rd, 32'h00000000);
        $display("test reserved_bits done");
    endtask : test_reserved

    task automatic test_underflow();
        wr(OFS_RELOAD_0, 32'h00000005);
        wr(OFS_COUNT_0, 32'h00000002);
        wr(OFS_CONTROL_0, 32'h00000020);
        expect_reg(OFS_COUNT_0, 32'h00000002);
        wr(OFS_RUN_SELECT, 32'h00000001);
        wait_event(0);
        wr(OFS_RUN_SELECT, 32'h00000000);
        axi_read(OFS_COUNT_0, rd, resp);
        check(rd <= 32'h00000005, 1'b1);
        expect_reg(OFS_CONTROL_0, 32'h00000120);
        check(unf_irq, 3'h1);
        wr(OFS_CONTROL_0, 32'h00000100);
        expect_reg(OFS_CONTROL_0, 32'h00000100);
        check(unf_irq, 3'h0);
        wr(OFS_CONTROL_0, 32'h00000000);
        expect_reg(OFS_CONTROL_0, 32'h00000000);
        expect_reg(OFS_IRQ_STATUS, 32'h00000001);
        check(irq, 1'b0);
        wr(OFS_IRQ_MASK, 32'h00000001);
        @(negedge aclk);
        check(irq, 1'b1);
        wr(OFS_IRQ_STATUS, 32'h00000001);
        @(negedge aclk);
        check(irq, 1'b0);
        expect_reg(OFS_IRQ_STATUS, 32'h00000000);
        $display("test underflow done");
    endtask : test_underflow

    task automatic test_power();
        wr(OFS_PIN_CONTROL, 32'h00000001);
        for (int e = 0; e < 3; e++)
        begin
            wr(OFS_CONTROL_1, 32'h00000004);
            wr(OFS_RUN_SELECT, 32'h00000003);
            @(posedge aclk);
            standby_mode <= (e == 0);
            mult_change  <= (e == 1);
            stop_bit     <= (e == 2);
            expect_reg(OFS_RUN_SELECT, 32'h00000002);
            wr(OFS_CONTROL_0, 32'h00000003);
            expect_reg(OFS_CONTROL_0, 32'h00000000);
            wr(OFS_CONTROL_1, 32'h00000024);
            expect_reg(OFS_CONTROL_1, 32'h00000024);
            expect_reg(OFS_PIN_CONTROL, 32'h00000001);
            @(posedge aclk);
            standby_mode <= 1'b0;
            mult_change  <= 1'b0;
            stop_bit     <= 1'b0;
        end
        wr(OFS_RUN_SELECT, 32'h00000000);
        wr(OFS_CONTROL_1, 32'h00000000);
        wr(OFS_PIN_CONTROL, 32'h00000000);
        $display("test power_events done");
    endtask : test_power

    task automatic test_capture();
        for (int e = 0; e < 3; e++)
        begin
            wr(OFS_COUNT_2, 32'h12345670 + 32'(e));
            wr(OFS_CONTROL_2, 32'h000000C0 | 32'(e << 3));
            @(negedge aclk);
            check(cap_irq, 1'b0);
            @(posedge aclk);
            pin_in <= ~pin_in;
            wait_event(1);
            expect_reg(OFS_CAPTURE_2, 32'h12345670 + 32'(e));
            expect_reg(OFS_CONTROL_2, 32'h000002C0 | 32'(e << 3));
        end
        wr(OFS_CONTROL_2, 32'h00000000);
        $display("test capture_edges done");
    endtask : test_capture

    initial
    begin
        req          = '0;
        aresetn      = 1'b0;
        standby_mode = 1'b0;
        mult_change  = 1'b0;
        stop_bit     = 1'b0;
        rtc_clk      = 1'b0;
        rtc_div      = 3'h0;
        pin_in       = 1'b0;
        err_count    = 0;
        checks_done  = 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        test_reset();
        test_reserved();
        test_underflow();
        test_power();
        test_capture();
        give_verdict();
    end

endmodule : tctr_top_test
